// ==== verilog/tmc_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module tmc_regs #(
    parameter int BIT_CYCLES = tmc_pkg::BIT_CYCLES
) (
    input wire logic mclk,                           // 200 MHz clock
    input wire logic arst_n,                         // Power-on reset
    input wire logic timer_rst,                      // Timer reset, sync
    input wire logic [7:0] sfr_addr,                 // Register address
    input wire logic [7:0] sfr_wdata,                // Write data
    input wire logic sfr_wr,                         // Write strobe
    input wire logic sfr_rd,                         // Read strobe
    output logic [7:0] sfr_rdata,                    // Read data, one cycle later
    output logic mod_active,                         // Modulator running
    output logic ask_mode,                           // 1 ASK, 0 FSK
    output logic iq_negative,                        // Negative phase, lower sideband
    output logic ram_access_mode,                    // Waveform RAM access mode
    output logic tx_bit,                             // Serial transmit bit
    output logic tx_bit_valid,                       // Byte being shifted
    output logic [tmc_pkg::FREQ_W-1:0] freq_word     // Freq = word * bbclk / 4096
);
    // A one-cycle bit period still needs a one-bit counter
    localparam int CW = (BIT_CYCLES > 1) ? $clog2(BIT_CYCLES) : 1;
    localparam int FW = tmc_pkg::FREQ_W;
    localparam int AW = tmc_pkg::RAM_ADDR_W;

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    logic [7:0] ctl_reg, ctl_next;
    logic [tmc_pkg::RAM_ADDR_W-1:0] addr_reg, addr_next;
    logic [7:0] offset_reg, offset_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [7:0] ram [tmc_pkg::RAM_WORDS];
    logic wr_ctl, wr_addr, wr_data, wr_off, wr_tx, ram_we;
    logic busy;
    logic run;

    tmc_stream_if #(.W(8)) txq ();

    assign wr_ctl = sfr_wr && sfr_addr == tmc_pkg::OFF_CONTROL;
    assign wr_addr = sfr_wr && sfr_addr == tmc_pkg::OFF_RAM_ADDR;
    assign wr_data = sfr_wr && sfr_addr == tmc_pkg::OFF_RAM_DATA;
    assign wr_off = sfr_wr && sfr_addr == tmc_pkg::OFF_OFFSET;
    assign wr_tx = sfr_wr && sfr_addr == tmc_pkg::OFF_TX_DATA;
    assign ram_we = wr_data && ctl_reg[tmc_pkg::CTL_RAM_ACC];
    assign busy = !txq.in_ready;

    always_comb begin
        ctl_next = ctl_reg;
        addr_next = addr_reg;
        offset_next = offset_reg;
        rdata_next = 8'h00;
        if (timer_rst) begin
            ctl_next = tmc_pkg::CONTROL_RESET;
        end else if (wr_ctl) begin
            // Bits 7, 6 and 0 are reserved and kept clear
            ctl_next = sfr_wdata & 8'h3E;
        end
        if (wr_addr && ctl_reg[tmc_pkg::CTL_RAM_ACC]) begin
            addr_next = sfr_wdata[tmc_pkg::RAM_ADDR_W-1:0];
        end
        if (wr_off) begin
            offset_next = sfr_wdata;
        end
        if (sfr_rd && sfr_addr == tmc_pkg::OFF_STATUS) begin
            rdata_next[tmc_pkg::STAT_BUSY] = busy;
            rdata_next[tmc_pkg::STAT_RSVD] = tmc_pkg::STAT_RSVD_VALUE;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ctl_reg <= tmc_pkg::CONTROL_RESET;
            addr_reg <= '0;
            offset_reg <= 8'h00;
            rdata_reg <= 8'h00;
        end else begin
            ctl_reg <= ctl_next;
            addr_reg <= addr_next;
            offset_reg <= offset_next;
            rdata_reg <= rdata_next;
        end
    end

    // Waveform RAM content is undefined after reset, as in silicon
    always_ff @(posedge mclk) begin
        if (ram_we) begin
            ram[addr_reg] <= sfr_wdata;
        end
    end

    assign sfr_rdata = rdata_reg;
    assign iq_negative = ctl_reg[tmc_pkg::CTL_SIDEBAND];
    assign mod_active = ctl_reg[tmc_pkg::CTL_MOD_EN];
    assign ask_mode = ctl_reg[tmc_pkg::CTL_ASK];
    assign ram_access_mode = ctl_reg[tmc_pkg::CTL_RAM_ACC];
    // Shifting needs modulator on, shift on and normal mode
    assign run = mod_active && ctl_reg[tmc_pkg::CTL_SHIFT_EN] && !ram_access_mode;

    // ----------------------------------------
    // Transmit byte buffer queue
    // ----------------------------------------
    // A write while full is dropped; software must poll busy first
    assign txq.in_valid = wr_tx;
    assign txq.in_data = sfr_wdata;

    tmc_fifo #(.W(8), .DEPTH(tmc_pkg::FIFO_DEPTH)) u_fifo (
        .mclk(mclk),
        .arst_n(arst_n),
        .flush(timer_rst),
        .st(txq)
    );

    // ----------------------------------------
    // Bit shifter
    // ----------------------------------------
    tmc_pkg::tmc_shift_state_t state_reg, state_next;
    logic [7:0] shift_reg, shift_next;
    logic [CW-1:0] cyc_reg, cyc_next;
    logic [2:0] bits_reg, bits_next;
    logic load;
    logic bit_end;
    logic last_bit;

    assign bit_end = cyc_reg == CW'(BIT_CYCLES - 1);
    assign last_bit = bits_reg == 3'h7;
    // Pop only when the shifter takes the byte in this cycle
    assign txq.out_ready = load;

    always_comb begin
        state_next = state_reg;
        shift_next = shift_reg;
        cyc_next = cyc_reg;
        bits_next = bits_reg;
        load = 1'b0;
        if (timer_rst) begin
            state_next = tmc_pkg::SH_IDLE;
            cyc_next = '0;
            bits_next = 3'h0;
        end else if (run) begin
            case (state_reg)
                tmc_pkg::SH_IDLE: begin
                    load = txq.out_valid;
                end
                tmc_pkg::SH_SHIFT: begin
                    if (!bit_end) begin
                        cyc_next = cyc_reg + CW'(1);
                    end else if (!last_bit) begin
                        // Most significant bit leaves first
                        cyc_next = '0;
                        shift_next = {shift_reg[6:0], 1'b0};
                        bits_next = bits_reg + 3'h1;
                    end else if (txq.out_valid) begin
                        // Next byte follows with no idle bit between
                        load = 1'b1;
                    end else begin
                        cyc_next = '0;
                        state_next = tmc_pkg::SH_IDLE;
                    end
                end
                default: begin
                    state_next = tmc_pkg::SH_IDLE;
                end
            endcase
            if (load) begin
                state_next = tmc_pkg::SH_SHIFT;
                shift_next = txq.out_data;
                cyc_next = '0;
                bits_next = 3'h0;
            end
        end
        // Without run only timer_rst acts above, so a half-sent byte freezes
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= tmc_pkg::SH_IDLE;
            shift_reg <= 8'h00;
            cyc_reg <= '0;
            bits_reg <= 3'h0;
        end else begin
            state_reg <= state_next;
            shift_reg <= shift_next;
            cyc_reg <= cyc_next;
            bits_reg <= bits_next;
        end
    end

    assign tx_bit = shift_reg[7];
    assign tx_bit_valid = state_reg == tmc_pkg::SH_SHIFT;

    // ----------------------------------------
    // Waveform pointer and frequency word
    // ----------------------------------------
    logic [AW-1:0] ptr_reg, ptr_next;
    logic [FW-1:0] freq_reg, freq_next;
    logic [FW-1:0] ram_term;
    logic [FW-1:0] offset_term;

    // Wide enough for 255 plus four times 255, so the sum never wraps
    assign ram_term = FW'(ram[ptr_reg]);
    assign offset_term = FW'(offset_reg) << tmc_pkg::OFFSET_SHIFT;

    always_comb begin
        ptr_next = ptr_reg;
        freq_next = '0;
        if (timer_rst) begin
            ptr_next = '0;
        end else if (tx_bit_valid && run && bit_end) begin
            // Waveform steps once per bit period
            ptr_next = ptr_reg + AW'(1);
        end
        if (mod_active && !ask_mode) begin
            freq_next = ram_term + offset_term;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ptr_reg <= '0;
            freq_reg <= '0;
        end else begin
            ptr_reg <= ptr_next;
            freq_reg <= freq_next;
        end
    end

    assign freq_word = freq_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    sideband_select_a: assert property (
        wr_ctl && !timer_rst |=> iq_negative == $past(sfr_wdata[tmc_pkg::CTL_SIDEBAND]))
        else $error("sideband bit not applied");

    modulator_enable_a: assert property (
        wr_ctl && !timer_rst |=> mod_active == $past(sfr_wdata[tmc_pkg::CTL_MOD_EN]))
        else $error("modulator enable not applied");

    ask_select_a: assert property (
        wr_ctl && !timer_rst |=> ask_mode == $past(sfr_wdata[tmc_pkg::CTL_ASK]))
        else $error("modulation type not applied");

    ram_mode_a: assert property (
        wr_ctl && !timer_rst |=> ram_access_mode == $past(sfr_wdata[tmc_pkg::CTL_RAM_ACC]))
        else $error("ram access bit not applied");

    shift_hold_a: assert property (
        !run |=> $stable(shift_reg))
        else $error("buffer moved while shifting is off");

    status_busy_a: assert property (
        sfr_rd && sfr_addr == tmc_pkg::OFF_STATUS |=> sfr_rdata[tmc_pkg::STAT_BUSY] == $past(busy))
        else $error("status busy bit wrong");

    addr_load_a: assert property (
        wr_addr && ram_access_mode |=> addr_reg == $past(sfr_wdata[AW-1:0]))
        else $error("ram address not loaded");

    addr_lock_a: assert property (
        wr_addr && !ram_access_mode |=> $stable(addr_reg))
        else $error("ram address changed outside access mode");

    back_to_back_c: cover property (
        tx_bit_valid && bit_end && last_bit && load);

    ram_load_c: cover property (ram_we);

    queue_full_c: cover property (busy && run);
endmodule
`default_nettype wire

// ==== verilog/tmc_pkg.sv ====
package tmc_pkg;
    // ----------------------------------------
    // Register offsets in the extended space
    // ----------------------------------------
    localparam logic [7:0] OFF_RAM_DATA = 8'hC9;
    localparam logic [7:0] OFF_RAM_ADDR = 8'hCA;
    localparam logic [7:0] OFF_TX_DATA = 8'hCB;
    localparam logic [7:0] OFF_OFFSET = 8'hD1;
    localparam logic [7:0] OFF_CONTROL = 8'hD3;
    localparam logic [7:0] OFF_STATUS = 8'hEB;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CTL_SIDEBAND = 5;
    localparam int CTL_MOD_EN = 4;
    localparam int CTL_ASK = 3;
    localparam int CTL_RAM_ACC = 2;
    localparam int CTL_SHIFT_EN = 1;
    localparam int STAT_BUSY = 7;
    localparam int STAT_RSVD = 6;
    localparam int OFFSET_SHIFT = 2;
    localparam int FREQ_DIV_BITS = 12;

    // ----------------------------------------
    // Reset values and counts
    // ----------------------------------------
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic STAT_RSVD_VALUE = 1'b1;
    localparam int BIT_CYCLES = 16;
    localparam int FIFO_DEPTH = 8;
    localparam int RAM_WORDS = 64;
    localparam int RAM_ADDR_W = 6;
    localparam int FREQ_W = 11;

    typedef enum logic [1:0] {
        SH_IDLE = 2'b00,
        SH_SHIFT = 2'b01
    } tmc_shift_state_t;
endpackage

// ==== verilog/tmc_stream_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface tmc_stream_if #(
    parameter int W = 8
);
    logic in_valid;
    logic in_ready;
    logic [W-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [W-1:0] out_data;

    modport buffer (
        input in_valid, in_data, out_ready,
        output in_ready, out_valid, out_data
    );
    modport user (
        output in_valid, in_data, out_ready,
        input in_ready, out_valid, out_data
    );
endinterface
`default_nettype wire

// ==== verilog/tmc_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module tmc_fifo #(
    parameter int W = 8,
    parameter int DEPTH = tmc_pkg::FIFO_DEPTH
) (
    input wire logic mclk,        // System clock
    input wire logic arst_n,      // Async reset
    input wire logic flush,       // Sync clear
    tmc_stream_if.buffer st       // Both sides of the buffer
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wr_reg, wr_next, rd_reg, rd_next;
    logic push, pop;

    assign st.in_ready = (wr_reg[AW] == rd_reg[AW]) || (wr_reg[AW-1:0] != rd_reg[AW-1:0]);
    assign st.out_valid = wr_reg != rd_reg;
    assign st.out_data = mem[rd_reg[AW-1:0]];
    assign push = st.in_valid && st.in_ready;
    assign pop = st.out_valid && st.out_ready;

    always_comb begin
        wr_next = wr_reg;
        rd_next = rd_reg;
        if (flush) begin
            wr_next = '0;
            rd_next = '0;
        end else begin
            if (push) begin
                wr_next = wr_reg + (AW+1)'(1);
            end
            if (pop) begin
                rd_next = rd_reg + (AW+1)'(1);
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
        end
    end

    // Storage has no reset; only pointers define content
    always_ff @(posedge mclk) begin
        if (push && !flush) begin
            mem[wr_reg[AW-1:0]] <= st.in_data;
        end
    end
endmodule
`default_nettype wire

// ==== tb/tmc_regs_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module tmc_regs_bench;
    // Short bit period keeps the shift scenario brief
    localparam int BC = 4;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic timer_rst = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_rdata;
    logic mod_active, ask_mode, iq_negative, ram_access_mode, tx_bit, tx_bit_valid;
    logic [tmc_pkg::FREQ_W-1:0] freq_word;
    int err_count = 0;
    int comparisons = 0;
    logic [7:0] d;

    always #2.5 mclk = ~mclk;

    tmc_regs #(.BIT_CYCLES(BC)) uut (
        .mclk(mclk), .arst_n(arst_n), .timer_rst(timer_rst), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
        .mod_active(mod_active), .ask_mode(ask_mode), .iq_negative(iq_negative),
        .ram_access_mode(ram_access_mode), .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid),
        .freq_word(freq_word)
    );

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge mclk);
        sfr_addr = a;
        sfr_wdata = v;
        sfr_wr = 1'b1;
        @(negedge mclk);
        sfr_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge mclk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge mclk);
        sfr_rd = 1'b0;
        v = sfr_rdata;
    endtask

    task automatic t_ctrl();
        logic [7:0] vals [5] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h3C};
        check("ctl_reset", {iq_negative, mod_active, ask_mode, ram_access_mode}, 16'h0);
        foreach (vals[i]) begin
            wr(tmc_pkg::OFF_CONTROL, vals[i]);
            check("ctl_out", {iq_negative, mod_active, ask_mode, ram_access_mode},
                  {12'h0, vals[i][5:2]});
        end
        // Timer reset clears every control bit
        @(negedge mclk);
        timer_rst = 1'b1;
        @(negedge mclk);
        timer_rst = 1'b0;
        check("ctl_timer", {iq_negative, mod_active, ask_mode, ram_access_mode}, 16'h0);
    endtask

    task automatic t_fsk();
        // Same byte everywhere, so any address stepping cannot matter
        wr(tmc_pkg::OFF_CONTROL, 8'h04);
        for (int i = 0; i < 64; i++) begin
            wr(tmc_pkg::OFF_RAM_ADDR, {2'b11, 6'(i)});
            wr(tmc_pkg::OFF_RAM_DATA, 8'h21);
        end
        wr(tmc_pkg::OFF_OFFSET, 8'h05);
        wr(tmc_pkg::OFF_CONTROL, 8'h10);
        repeat (4) @(negedge mclk);
        check("freq_word", 16'(freq_word), 16'h0035);
        for (int i = 0; i < 8; i++) begin
            wr(tmc_pkg::OFF_RAM_ADDR, 8'(i));
            wr(tmc_pkg::OFF_RAM_DATA, 8'h7F);
        end
        repeat (4) @(negedge mclk);
        check("freq_locked", 16'(freq_word), 16'h0035);
    endtask

    task automatic t_shift();
        logic [7:0] b = 8'h00;
        int n = 0;
        rd(tmc_pkg::OFF_STATUS, d);
        check("stat_idle", d[7:6], 16'h1);
        for (int i = 0; i < 8; i++) wr(tmc_pkg::OFF_TX_DATA, 8'hA5);
        repeat (40) begin
            @(negedge mclk);
            check("no_shift", tx_bit_valid, 16'h0);
        end
        rd(tmc_pkg::OFF_STATUS, d);
        check("stat_full", d[7], 16'h1);
        wr(tmc_pkg::OFF_CONTROL, 8'h12);
        while (tx_bit_valid !== 1'b1 && n < 100) begin
            @(negedge mclk);
            n++;
        end
        check("shift_start", tx_bit_valid, 16'h1);
        repeat (BC / 2) @(negedge mclk);
        for (int k = 0; k < 8; k++) begin
            b = {b[6:0], tx_bit};
            repeat (BC) @(negedge mclk);
        end
        // Palindromic byte hides the bit order choice
        check("tx_byte", b, 16'h00A5);
        repeat (9 * 8 * BC + 20) @(negedge mclk);
        rd(tmc_pkg::OFF_STATUS, d);
        check("stat_drained", d[7:6], 16'h1);
        check("tx_done", tx_bit_valid, 16'h0);
    endtask

    task automatic end_sim();
        if (err_count == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(negedge mclk);
        arst_n = 1'b1;
        t_ctrl();
        t_fsk();
        t_shift();
        end_sim();
    end

    initial begin
        #(5 * 20000);
        err_count++;
        end_sim();
    end
endmodule
`default_nettype wire
